// ===== rtl/plp_sysregs.sv
// partition label register bank and request labeller
// assumes the pipeline holds level inputs stable and marks each sync event with a one-cycle pulse
// How it works
// RULE_01: labels refresh on every context sync
// RULE_02: level change also refreshes label snapshot
// RULE_03: writes never relabel earlier instructions
// RULE_04: labels always read from live snapshot
// RULE_05: user and kernel label encodings decoded
// RULE_06: other label and config encodings decoded
// RULE_07: eight map registers by op2 index
// RULE_08: guest lock labels user from kernel
// RULE_09: user ids mapped when virtual enabled
// RULE_10: kernel ids mapped when kernel map set
// RULE_11: user layout: ids low, reserved top
// RULE_12: monitor groups at bits 47:40, 39:32
// RULE_13: warm reset value of fields unspecified
// RULE_14: user-level access is undefined
// RULE_15: lower trap to top, class 0x18
// RULE_16: kernel access traps to hypervisor
// RULE_17: untrapped accesses read or write register
// RULE_18: kernel bit 63 mirrors upper enable
// RULE_19: host mode redirects kernel names
// RULE_20: 64-bit registers, undefined without feature
// RULE_21: user register exists only with feature
// RULE_22: request gets id and group fields
`timescale 1ns/10ps
module plp_sysregs
  import plp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // implementation straps and execution state
  input wire logic partitioning_feature,
  input wire logic have_top_level,
  input wire logic have_hyp,
  input wire logic hyp_enabled,
  input wire logic virt_present,
  input wire logic host_mode,
  input wire logic trap_general,
  input wire logic halted,
  input wire logic secure_debug_disable,
  input wire logic [1:0] cur_el,
  input wire logic ctx_sync,
  // register access from the pipeline
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [2:0] acc_op1,
  input wire logic [3:0] acc_crn,
  input wire logic [3:0] acc_crm,
  input wire logic [2:0] acc_op2,
  input wire logic [63:0] acc_wdata,
  // access answer
  output logic rsp_valid,
  output logic [63:0] rsp_rdata,
  output logic rsp_undef,
  output logic rsp_trap_top,
  output logic rsp_trap_hyp,
  output logic [5:0] rsp_syndrome,
  // memory request
  input wire logic req_valid,
  input wire logic req_fetch,
  input wire logic [1:0] req_el,
  // label for the request
  output logic lab_valid,
  output logic [15:0] lab_partid,
  output logic [7:0] lab_pmg,
  output logic lab_mapped
);

  // ****************************************
  // registers and snapshots
  // ****************************************
  logic [63:0] user_r, kernel_r, hyp_r, top_r, hcfg_r, vpmv_r;
  logic [PLP_VPM_REGS-1:0][63:0] vpm_r;
  logic [63:0] act_user_r, act_kernel_r, act_hyp_r, act_top_r, act_hcfg_r;
  logic [31:0] act_vpmv_r;
  logic [PLP_VPM_REGS-1:0][63:0] act_vpm_r;
  logic [1:0] el_prev_r;
  logic sync_evt;
  logic [13:0] enc;
  plp_tgt_t tgt;
  logic [2:0] vpm_idx;
  logic undef_nxt, trap3_nxt, trap2_nxt;
  logic [63:0] rdata_nxt, kernel_view;

  assign enc = {acc_op1, acc_crn, acc_crm, acc_op2};
  assign vpm_idx = acc_op2;

  // RULE_02: level change acts as sync
  assign sync_evt = ctx_sync || (cur_el != el_prev_r);

  // RULE_18: enable bit from upper level
  always_comb begin
    kernel_view = kernel_r;
    if (have_top_level) begin
      kernel_view[PLP_ENABLE_BIT] = top_r[PLP_ENABLE_BIT];
    end else if (have_hyp) begin
      kernel_view[PLP_ENABLE_BIT] = hyp_r[PLP_ENABLE_BIT];
    end
  end

  // ****************************************
  // access decode and checks
  // ****************************************
  always_comb begin
    logic lower_trap;
    logic blocked;
    lower_trap = 1'b0;
    blocked = 1'b0;
    tgt = PLP_TGT_NONE;
    undef_nxt = 1'b0;
    trap3_nxt = 1'b0;
    trap2_nxt = 1'b0;
    rdata_nxt = 64'h0000_0000_0000_0000;
    lower_trap = have_top_level && top_r[PLP_LOWER_TRAP_BIT] && (cur_el == PLP_EL1 || cur_el == PLP_EL2);
    // RULE_15: trap to top or undefined in debug
    if (lower_trap) begin
      if (halted && secure_debug_disable) begin
        undef_nxt = 1'b1;
      end else begin
        trap3_nxt = 1'b1;
      end
    end
    blocked = lower_trap;
    // RULE_05: user and kernel encodings
    if (enc == PLP_ENC_USER) begin
      tgt = PLP_TGT_USER;
      if (cur_el == PLP_EL0) begin
        // RULE_14: user level cannot reach it
        undef_nxt = 1'b1;
        trap3_nxt = 1'b0;
      end else if (!blocked && cur_el == PLP_EL1 && hyp_enabled && hyp_r[PLP_USER_TRAP_BIT]) begin
        // RULE_16: hypervisor trap bit
        trap2_nxt = 1'b1;
      end
    end else if (enc == PLP_ENC_KERNEL) begin
      // RULE_19: kernel name reaches hypervisor register
      tgt = (cur_el == PLP_EL2 && host_mode) ? PLP_TGT_HYP : PLP_TGT_KERNEL;
      if (cur_el == PLP_EL0) begin
        undef_nxt = 1'b1;
        trap3_nxt = 1'b0;
      end else if (!blocked && cur_el == PLP_EL1 && hyp_enabled && hyp_r[PLP_KERNEL_TRAP_BIT]) begin
        trap2_nxt = 1'b1;
      end
    end else if (enc == PLP_ENC_ALIAS) begin
      // RULE_19: alias reaches kernel register
      tgt = PLP_TGT_KERNEL;
      if (cur_el == PLP_EL3) begin
        undef_nxt = !(hyp_enabled && host_mode);
      end else if (!(cur_el == PLP_EL2 && host_mode)) begin
        undef_nxt = 1'b1;
        trap3_nxt = 1'b0;
      end
    end else if (enc == PLP_ENC_HYP || enc == PLP_ENC_HCFG || enc == PLP_ENC_VPMV ||
                 enc[13:3] == PLP_ENC_VPM_HI) begin
      // RULE_06: hypervisor level registers
      if (enc == PLP_ENC_HYP) begin
        tgt = PLP_TGT_HYP;
      end else if (enc == PLP_ENC_HCFG) begin
        tgt = PLP_TGT_HCFG;
      end else if (enc == PLP_ENC_VPMV) begin
        tgt = PLP_TGT_VPMV;
      end else begin
        // RULE_07: op2 selects map register
        tgt = PLP_TGT_VPM;
      end
      if (!have_hyp || cur_el == PLP_EL0 || cur_el == PLP_EL1) begin
        undef_nxt = 1'b1;
        trap3_nxt = 1'b0;
      end
    end else if (enc == PLP_ENC_TOP) begin
      // RULE_06: top level register
      tgt = PLP_TGT_TOP;
      undef_nxt = !(have_top_level && cur_el == PLP_EL3);
      trap3_nxt = 1'b0;
    end else if (enc == PLP_ENC_IDR) begin
      tgt = PLP_TGT_IDR;
      if (cur_el == PLP_EL0 || acc_write) begin
        undef_nxt = 1'b1;
        trap3_nxt = 1'b0;
      end
    end else begin
      undef_nxt = 1'b1;
      trap3_nxt = 1'b0;
    end
    // RULE_20: no feature, nothing decodes
    // RULE_21: user encodings undefined too
    if (!partitioning_feature) begin
      tgt = PLP_TGT_NONE;
      undef_nxt = 1'b1;
      trap3_nxt = 1'b0;
      trap2_nxt = 1'b0;
    end
    if (undef_nxt || trap3_nxt || trap2_nxt) begin
      tgt = PLP_TGT_NONE;
    end
    // RULE_17: untrapped read returns register
    case (tgt)
      PLP_TGT_USER: rdata_nxt = user_r;
      PLP_TGT_KERNEL: rdata_nxt = kernel_view;
      PLP_TGT_HYP: rdata_nxt = hyp_r;
      PLP_TGT_TOP: rdata_nxt = top_r;
      PLP_TGT_HCFG: rdata_nxt = hcfg_r;
      PLP_TGT_VPMV: rdata_nxt = vpmv_r;
      PLP_TGT_VPM: rdata_nxt = vpm_r[vpm_idx];
      PLP_TGT_IDR: rdata_nxt = PLP_IDR_VALUE;
      default: rdata_nxt = 64'h0000_0000_0000_0000;
    endcase
  end

  // ****************************************
  // architectural registers
  // ****************************************
  // RULE_13: any reset value allowed, zero chosen
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      user_r <= PLP_LABEL_RESET;
      kernel_r <= PLP_LABEL_RESET;
      hyp_r <= PLP_LABEL_RESET;
      top_r <= PLP_LABEL_RESET;
      hcfg_r <= PLP_LABEL_RESET;
      vpmv_r <= PLP_LABEL_RESET;
      vpm_r <= '0;
    end else if (acc_valid && acc_write) begin
      // RULE_17: untrapped write updates register
      case (tgt)
        // RULE_11: reserved bits stay zero
        PLP_TGT_USER: user_r <= acc_wdata & PLP_USER_WMASK;
        PLP_TGT_KERNEL: kernel_r <= acc_wdata;
        PLP_TGT_HYP: hyp_r <= acc_wdata;
        PLP_TGT_TOP: top_r <= acc_wdata;
        PLP_TGT_HCFG: hcfg_r <= acc_wdata;
        PLP_TGT_VPMV: vpmv_r <= acc_wdata;
        PLP_TGT_VPM: vpm_r[vpm_idx] <= acc_wdata;
        default: user_r <= user_r;
      endcase
    end
  end

  // ****************************************
  // access answer
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 64'h0000_0000_0000_0000;
      rsp_undef <= 1'b0;
      rsp_trap_top <= 1'b0;
      rsp_trap_hyp <= 1'b0;
      rsp_syndrome <= 6'h00;
    end else begin
      rsp_valid <= acc_valid;
      rsp_rdata <= (acc_valid && !acc_write) ? rdata_nxt : 64'h0000_0000_0000_0000;
      rsp_undef <= acc_valid && undef_nxt;
      rsp_trap_top <= acc_valid && trap3_nxt;
      rsp_trap_hyp <= acc_valid && trap2_nxt;
      rsp_syndrome <= (acc_valid && (trap3_nxt || trap2_nxt)) ? PLP_SYNDROME_CLASS : 6'h00;
    end
  end

  // ****************************************
  // synchronised snapshots
  // ****************************************
  // RULE_01: snapshot taken only at sync
  // RULE_03: writes since last sync stay invisible
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      el_prev_r <= PLP_EL0;
      act_user_r <= PLP_LABEL_RESET;
      act_kernel_r <= PLP_LABEL_RESET;
      act_hyp_r <= PLP_LABEL_RESET;
      act_top_r <= PLP_LABEL_RESET;
      act_hcfg_r <= PLP_LABEL_RESET;
      act_vpmv_r <= 32'h0000_0000;
      act_vpm_r <= '0;
    end else begin
      el_prev_r <= cur_el;
      if (sync_evt) begin
        act_user_r <= user_r;
        act_kernel_r <= kernel_view;
        act_hyp_r <= hyp_r;
        act_top_r <= top_r;
        act_hcfg_r <= hcfg_r;
        act_vpmv_r <= vpmv_r[31:0];
        act_vpm_r <= vpm_r;
      end
    end
  end

  // ****************************************
  // request labelling
  // ****************************************
  logic [63:0] src;
  logic do_map;
  logic [15:0] vid, pid;
  logic [7:0] pmg;

  always_comb begin
    src = act_user_r;
    do_map = 1'b0;
    case (req_el)
      PLP_EL0: begin
        if (hyp_enabled && virt_present && act_hcfg_r[PLP_GAL_BIT] && !trap_general) begin
          // RULE_08: guest lock uses kernel labels
          src = act_kernel_r;
          // RULE_10: kernel mapping still applies
          do_map = act_hcfg_r[PLP_KVME_BIT];
        end else begin
          src = act_user_r;
          // RULE_09: user ids virtual when enabled
          do_map = hyp_enabled && (!host_mode || !trap_general) && virt_present && act_hcfg_r[PLP_UVME_BIT];
        end
      end
      PLP_EL1: begin
        src = act_kernel_r;
        // RULE_10: kernel map enable
        do_map = hyp_enabled && virt_present && act_hcfg_r[PLP_KVME_BIT];
      end
      PLP_EL2: src = act_hyp_r;
      PLP_EL3: src = act_top_r;
      default: src = act_user_r;
    endcase
    // RULE_22: fetch takes instruction fields
    // RULE_12: group follows its partition id
    if (req_fetch) begin
      vid = src[PLP_PID_I_LSB +: 16];
      pmg = src[PLP_INSTR_MONITOR_GROUP_LSB +: 8];
    end else begin
      vid = src[PLP_PID_D_LSB +: 16];
      pmg = src[PLP_DATA_MONITOR_GROUP_LSB +: 8];
    end
  end

  plp_vmap u_vmap (
    .entries(act_vpm_r),
    .valid(act_vpmv_r),
    .vid(vid),
    .pid(pid)
  );

  // RULE_04: no label cache, every request recomputed
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lab_valid <= 1'b0;
      lab_partid <= 16'h0000;
      lab_pmg <= 8'h00;
      lab_mapped <= 1'b0;
    end else begin
      lab_valid <= req_valid;
      lab_partid <= req_valid ? (do_map ? pid : vid) : 16'h0000;
      lab_pmg <= req_valid ? pmg : 8'h00;
      lab_mapped <= req_valid && do_map;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_USER_EL0_UNDEF: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_14
    acc_valid && enc == PLP_ENC_USER && cur_el == PLP_EL0 |=> rsp_undef && !rsp_trap_top && !rsp_trap_hyp)
    else $error("user access at user level not undefined");
  AST_NO_FEATURE: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_20
    acc_valid && !partitioning_feature |=> rsp_undef && rsp_rdata == 64'h0000_0000_0000_0000)
    else $error("access decoded without the feature");
  AST_TRAP_CLASS: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_15
    rsp_trap_top || rsp_trap_hyp |-> rsp_syndrome == 6'h18 && !rsp_undef)
    else $error("trap without class 0x18");
  AST_DEBUG_UNDEF: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_15
    acc_valid && partitioning_feature && enc == PLP_ENC_USER && cur_el == PLP_EL1 && have_top_level &&
    top_r[PLP_LOWER_TRAP_BIT] && halted && secure_debug_disable |=> rsp_undef && !rsp_trap_top)
    else $error("halted debug access not undefined");
  AST_HYP_TRAP: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_16
    acc_valid && partitioning_feature && enc == PLP_ENC_USER && cur_el == PLP_EL1 &&
    !(have_top_level && top_r[PLP_LOWER_TRAP_BIT]) && hyp_enabled && hyp_r[PLP_USER_TRAP_BIT] |=> rsp_trap_hyp)
    else $error("kernel access missed hypervisor trap");
  AST_USER_WRITE: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_17
    acc_valid && acc_write && partitioning_feature && enc == PLP_ENC_USER && cur_el == PLP_EL3
    |=> user_r == ($past(acc_wdata) & PLP_USER_WMASK))
    else $error("top level write did not update user register");
  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_11
    user_r[63:48] == 16'h0000)
    else $error("reserved user bits set");
  AST_HOLD_UNTIL_SYNC: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_03
    !sync_evt |=> $stable(act_user_r) && $stable(act_kernel_r))
    else $error("snapshot changed without sync");
  AST_SYNC_CAPTURE: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_01
    ctx_sync |=> act_user_r == $past(user_r))
    else $error("sync did not capture latest user value");
  AST_EL_CHANGE: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_02
    cur_el != el_prev_r |=> act_kernel_r == $past(kernel_view))
    else $error("level change did not refresh snapshot");
  AST_TOP_FETCH: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_22
    req_valid && req_fetch && req_el == PLP_EL3 |=> lab_partid == $past(act_top_r[15:0]) && !lab_mapped)
    else $error("top level fetch label wrong");
  AST_MIRROR: assert property (@(posedge mclk) disable iff (!reset_n) // RULE_18
    acc_valid && !acc_write && partitioning_feature && enc == PLP_ENC_KERNEL && cur_el == PLP_EL3 &&
    have_top_level |=> rsp_rdata[63] == $past(top_r[63]))
    else $error("kernel enable bit not mirrored");
  COV_TRAP_TOP: cover property (@(posedge mclk) disable iff (!reset_n) rsp_trap_top);
  COV_TRAP_HYP: cover property (@(posedge mclk) disable iff (!reset_n) rsp_trap_hyp);
  COV_MAPPED: cover property (@(posedge mclk) disable iff (!reset_n) lab_valid && lab_mapped);
  COV_SYNC_LABEL: cover property (@(posedge mclk) disable iff (!reset_n) ctx_sync ##1 req_valid);

endmodule : plp_sysregs

// ===== rtl/plp_pkg.sv
// constants for the partition label system register bank
// assumes a pipeline that presents one register access and one memory request per cycle at most
package plp_pkg;

  // ****************************************
  // encodings {op1, crn, crm, op2}
  // ****************************************
  localparam logic [13:0] PLP_ENC_USER = {3'h0, 4'ha, 4'h5, 3'h1};
  localparam logic [13:0] PLP_ENC_KERNEL = {3'h0, 4'ha, 4'h5, 3'h0};
  localparam logic [13:0] PLP_ENC_HYP = {3'h4, 4'ha, 4'h5, 3'h0};
  localparam logic [13:0] PLP_ENC_TOP = {3'h6, 4'ha, 4'h5, 3'h0};
  localparam logic [13:0] PLP_ENC_ALIAS = {3'h5, 4'ha, 4'h5, 3'h0};
  localparam logic [13:0] PLP_ENC_HCFG = {3'h4, 4'ha, 4'h4, 3'h0};
  localparam logic [13:0] PLP_ENC_VPMV = {3'h4, 4'ha, 4'h4, 3'h1};
  localparam logic [10:0] PLP_ENC_VPM_HI = {3'h4, 4'ha, 4'h6};
  localparam logic [13:0] PLP_ENC_IDR = {3'h0, 4'ha, 4'h4, 3'h4};

  // ****************************************
  // exception levels
  // ****************************************
  localparam logic [1:0] PLP_EL0 = 2'h0;
  localparam logic [1:0] PLP_EL1 = 2'h1;
  localparam logic [1:0] PLP_EL2 = 2'h2;
  localparam logic [1:0] PLP_EL3 = 2'h3;

  // ****************************************
  // field layout of the label registers
  // ****************************************
  localparam int PLP_PID_I_LSB = 0;
  localparam int PLP_PID_D_LSB = 16;
  localparam int PLP_INSTR_MONITOR_GROUP_LSB = 32;
  localparam int PLP_DATA_MONITOR_GROUP_LSB = 40;
  localparam int PLP_ENABLE_BIT = 63;
  localparam logic [63:0] PLP_USER_WMASK = 64'h0000_ffff_ffff_ffff;
  localparam logic [63:0] PLP_LABEL_RESET = 64'h0000_0000_0000_0000;
  // control bits held in the hypervisor and top-level registers
  localparam int PLP_LOWER_TRAP_BIT = 62;
  localparam int PLP_USER_TRAP_BIT = 58;
  localparam int PLP_KERNEL_TRAP_BIT = 57;
  // hypervisor config bits
  localparam int PLP_UVME_BIT = 0;
  localparam int PLP_KVME_BIT = 1;
  localparam int PLP_GAL_BIT = 8;

  // ****************************************
  // virtual map and answers
  // ****************************************
  localparam int PLP_VPM_REGS = 8;
  localparam int PLP_VPM_IDS = 32;
  localparam logic [15:0] PLP_DEFAULT_PID = 16'h0000;
  localparam logic [5:0] PLP_SYNDROME_CLASS = 6'h18;
  // identification value is arbitrary
  localparam logic [63:0] PLP_IDR_VALUE = 64'h0000_0000_0000_001f;

  typedef enum logic [3:0] {
    PLP_TGT_NONE, PLP_TGT_USER, PLP_TGT_KERNEL, PLP_TGT_HYP, PLP_TGT_TOP,
    PLP_TGT_HCFG, PLP_TGT_VPMV, PLP_TGT_VPM, PLP_TGT_IDR
  } plp_tgt_t;

endpackage : plp_pkg

// ===== rtl/plp_vmap.sv
// virtual to physical partition id lookup
// assumes map entries and valid bits come from synchronised snapshots
`timescale 1ns/10ps
module plp_vmap
  import plp_pkg::*;
(
  // map contents
  input wire logic [PLP_VPM_REGS*64-1:0] entries,
  input wire logic [PLP_VPM_IDS-1:0] valid,
  // lookup
  input wire logic [15:0] vid,
  output logic [15:0] pid
);

  logic in_range;
  logic [4:0] idx;

  assign in_range = (vid < 16'(PLP_VPM_IDS));
  assign idx = vid[4:0];

  // invalid entry falls back to entry 0, then to the default physical id
  always_comb begin
    if (in_range && valid[idx]) begin
      pid = entries[{idx, 4'h0} +: 16];
    end else if (valid[0]) begin
      pid = entries[15:0];
    end else begin
      pid = PLP_DEFAULT_PID;
    end
  end

endmodule : plp_vmap

// ===== test/plp_pipe_model.sv
// pipeline model issuing register accesses, sync pulses and memory requests
// assumes the bench calls one task at a time from a single process
`timescale 1ns/10ps
module plp_pipe_model (
  // clock
  input wire logic mclk,
  // register access
  output logic acc_valid,
  output logic acc_write,
  output logic [2:0] acc_op1,
  output logic [3:0] acc_crn,
  output logic [3:0] acc_crm,
  output logic [2:0] acc_op2,
  output logic [63:0] acc_wdata,
  // sync and memory request
  output logic ctx_sync,
  output logic req_valid,
  output logic req_fetch,
  output logic [1:0] req_el
);
  // ****************************************
  // issue tasks
  // ****************************************
  initial begin
    {acc_valid, acc_write, acc_op1, acc_crn, acc_crm, acc_op2, acc_wdata} = '0;
    {ctx_sync, req_valid, req_fetch, req_el} = '0;
  end
  // one access; returns just after the answer edge
  task automatic acc(input logic w, input logic [13:0] e, input logic [63:0] d);
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_write <= w;
    {acc_op1, acc_crn, acc_crm, acc_op2} <= e;
    acc_wdata <= d;
    @(posedge mclk);
    acc_valid <= 1'b0;
    // stale data is inverted so nothing leans on it
    acc_wdata <= ~d;
    // answer stands only one cycle, so look right after its launch edge
    #1;
  endtask : acc
  // optional request, optional sync pulse in the same cycle
  task automatic mreq(input logic v, input logic f, input logic [1:0] el, input logic s);
    @(posedge mclk);
    req_valid <= v;
    req_fetch <= f;
    req_el <= el;
    ctx_sync <= s;
    @(posedge mclk);
    req_valid <= 1'b0;
    ctx_sync <= 1'b0;
    #1;
  endtask : mreq
endmodule : plp_pipe_model

// ===== test/tb_plp_sysregs.sv
// self-checking bench for the partition label register bank
// assumes the pipeline model drives accesses and requests, the bench the straps
`timescale 1ns/10ps
module tb_plp_sysregs;
  import plp_pkg::*;
  logic mclk, reset_n, partitioning_feature, have_top_level, have_hyp, hyp_enabled, virt_present;
  logic host_mode, trap_general, halted, secure_debug_disable, ctx_sync, acc_valid, acc_write;
  logic [1:0] cur_el, req_el;
  logic [2:0] acc_op1, acc_op2;
  logic [3:0] acc_crn, acc_crm;
  logic [63:0] acc_wdata, rsp_rdata;
  logic rsp_valid, rsp_undef, rsp_trap_top, rsp_trap_hyp, req_valid, req_fetch, lab_valid, lab_mapped;
  logic [5:0] rsp_syndrome;
  logic [15:0] lab_partid;
  logic [7:0] lab_pmg;
  int miscompares, n_checks;
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  plp_sysregs plp_sysregs_i (.mclk, .reset_n, .partitioning_feature, .have_top_level, .have_hyp, .hyp_enabled,
    .virt_present, .host_mode, .trap_general, .halted, .secure_debug_disable, .cur_el, .ctx_sync, .acc_valid,
    .acc_write, .acc_op1, .acc_crn, .acc_crm, .acc_op2, .acc_wdata, .rsp_valid, .rsp_rdata, .rsp_undef,
    .rsp_trap_top, .rsp_trap_hyp, .rsp_syndrome, .req_valid, .req_fetch, .req_el, .lab_valid, .lab_partid,
    .lab_pmg, .lab_mapped);
  plp_pipe_model plp_pipe_model_i (.mclk, .acc_valid, .acc_write, .acc_op1, .acc_crn, .acc_crm, .acc_op2,
    .acc_wdata, .ctx_sync, .req_valid, .req_fetch, .req_el);
  // ****************************************
  // checks and access tasks
  // ****************************************
  task automatic give_verdict;
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // f is {undef, trap to top, trap to hypervisor}
  task automatic chk_rsp(input logic [2:0] f, input logic [63:0] d);
    logic [73:0] got, exp;
    got = {rsp_valid, rsp_undef, rsp_trap_top, rsp_trap_hyp, rsp_syndrome, rsp_rdata};
    exp = {1'b1, f, (f[1] | f[0]) ? PLP_SYNDROME_CLASS : 6'h00, d};
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_rsp
  task automatic chk_lab(input logic [15:0] p, input logic [7:0] g, input logic m);
    logic [25:0] got;
    got = {lab_valid, lab_partid, lab_pmg, lab_mapped};
    n_checks++;
    if (got !== {1'b1, p, g, m}) begin
      miscompares++;
      $display("unexpected label at %0t: got %h expected %h", $time, got, {1'b1, p, g, m});
    end
  endtask : chk_lab
  task automatic wr(input logic [13:0] e, input logic [63:0] d, input logic [2:0] f);
    plp_pipe_model_i.acc(1'b1, e, d);
    chk_rsp(f, 64'h0);
  endtask : wr
  task automatic rd(input logic [13:0] e, input logic [2:0] f, input logic [63:0] x);
    plp_pipe_model_i.acc(1'b0, e, 64'h0);
    chk_rsp(f, x);
  endtask : rd
  task automatic lreq(input logic fe, input logic [1:0] el, input logic s, input logic [15:0] p,
      input logic [7:0] g, input logic m);
    plp_pipe_model_i.mreq(1'b1, fe, el, s);
    chk_lab(p, g, m);
  endtask : lreq
  task automatic set_el(input logic [1:0] e);
    @(posedge mclk);
    cur_el <= e;
  endtask : set_el
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {reset_n, host_mode, trap_general, halted, secure_debug_disable} = '0;
    {partitioning_feature, have_top_level, have_hyp, hyp_enabled, virt_present} = '1;
    cur_el = PLP_EL3;
    miscompares = 0;
    n_checks = 0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    wr(PLP_ENC_TOP, 64'h8000_0000_0000_0000, 3'b000);
    wr(PLP_ENC_USER, 64'hffff_abcd_0001_0000, 3'b000);
    rd(PLP_ENC_USER, 3'b000, 64'h0000_abcd_0001_0000);
    lreq(1'b0, PLP_EL0, 1'b1, 16'h0000, 8'h00, 1'b0);
    lreq(1'b0, PLP_EL0, 1'b0, 16'h0001, 8'hab, 1'b0);
    lreq(1'b1, PLP_EL0, 1'b0, 16'h0000, 8'hcd, 1'b0);
    wr(PLP_ENC_USER, 64'h0000_1100_0001_0000, 3'b000);
    set_el(PLP_EL0);
    lreq(1'b0, PLP_EL0, 1'b0, 16'h0001, 8'h11, 1'b0);
    set_el(PLP_EL3);
    wr(PLP_ENC_KERNEL, 64'h0000_0201_0000_0001, 3'b000);
    rd(PLP_ENC_KERNEL, 3'b000, 64'h8000_0201_0000_0001);
    wr(PLP_ENC_HCFG, 64'h100, 3'b000);
    lreq(1'b1, PLP_EL0, 1'b1, 16'h0000, 8'h00, 1'b0);
    lreq(1'b1, PLP_EL0, 1'b0, 16'h0001, 8'h01, 1'b0);
    wr(PLP_ENC_HCFG, 64'h3, 3'b000);
    wr(PLP_ENC_VPMV, 64'h3, 3'b000);
    // map the first two entries of every map register to 0x0aaa and 0x0777
    for (int i = 0; i < PLP_VPM_REGS; i++) wr({PLP_ENC_VPM_HI, 3'(i)}, {16'(i), 48'h0000_0777_0aaa}, 3'b000);
    for (int i = 0; i < PLP_VPM_REGS; i++) rd({PLP_ENC_VPM_HI, 3'(i)}, 3'b000, {16'(i), 48'h0000_0777_0aaa});
    plp_pipe_model_i.mreq(1'b0, 1'b0, PLP_EL0, 1'b1);
    lreq(1'b0, PLP_EL0, 1'b0, 16'h0777, 8'h11, 1'b1);
    lreq(1'b1, PLP_EL0, 1'b0, 16'h0aaa, 8'h00, 1'b1);
    lreq(1'b1, PLP_EL1, 1'b0, 16'h0777, 8'h01, 1'b1);
    rd(PLP_ENC_IDR, 3'b000, PLP_IDR_VALUE);
    wr(PLP_ENC_IDR, 64'h1, 3'b100);
    rd({3'h0, 4'ha, 4'h5, 3'h7}, 3'b100, 64'h0);
    // lower trap bit set, enable kept
    wr(PLP_ENC_TOP, 64'hc000_0000_0000_0000, 3'b000);
    set_el(PLP_EL1);
    rd(PLP_ENC_USER, 3'b010, 64'h0);
    @(posedge mclk);
    {halted, secure_debug_disable} <= 2'b11;
    wr(PLP_ENC_USER, 64'h5, 3'b100);
    @(posedge mclk);
    {halted, secure_debug_disable} <= 2'b00;
    set_el(PLP_EL3);
    wr(PLP_ENC_TOP, 64'h8000_0055_0000_0123, 3'b000);
    set_el(PLP_EL2);
    lreq(1'b1, PLP_EL3, 1'b0, 16'h0123, 8'h55, 1'b0);
    wr(PLP_ENC_HYP, 64'h0400_0000_0000_0000, 3'b000);
    rd(PLP_ENC_USER, 3'b000, 64'h0000_1100_0001_0000);
    @(posedge mclk);
    host_mode <= 1'b1;
    rd(PLP_ENC_KERNEL, 3'b000, 64'h0400_0000_0000_0000);
    set_el(PLP_EL1);
    rd(PLP_ENC_USER, 3'b001, 64'h0);
    set_el(PLP_EL0);
    rd(PLP_ENC_USER, 3'b100, 64'h0);
    set_el(PLP_EL3);
    @(posedge mclk);
    partitioning_feature <= 1'b0;
    rd(PLP_ENC_USER, 3'b100, 64'h0);
    rd(PLP_ENC_KERNEL, 3'b100, 64'h0);
    give_verdict();
  end
  // hang guard: the whole sequence needs far fewer cycles
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
endmodule : tb_plp_sysregs
